// ===== pmr_result_regs.sv
// result and calibration register bank of a current and power monitor
// assumes the converter gives finished (averaged) readings with a one-cycle
// meas_valid pulse, and the serial port gives a register pointer and strobes
//
// How it works
// RULE1: bus register takes each newer bus reading that arrives while the sequencer is in PMR_IDLE
// RULE2: only finished averaged readings are stored
// RULE3: bus result top bit always reads zero
// RULE4: power step equals 25 current steps
// RULE5: power is current times bus voltage
// RULE6: power is unsigned sixteen bits, never negative
// RULE7: current is shunt drop times calibration
// RULE8: current result is signed, top bit sign
// RULE9: calibration write sets current and power step
// RULE10: calibration keeps only fifteen bits, top zero
// RULE11: shunt drop taken as two's complement
// RULE12: shunt drop counts 2.5 uV, full 7fff
// RULE13: results update together after conversion completes
// RULE14: all four registers reset to zero
`include "pmr_defines.svh"
`default_nettype none

module pmr_result_regs
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        meas_valid,
  input  wire logic [15:0] shunt_drop_reading,
  input  wire logic [15:0] bus_voltage_reading,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             results_updated
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // true when the pointer names a register of this bank
  function automatic logic pmr_hit(input logic [7:0] addr);
    pmr_hit = (addr == `PMR_ADDR_BUS_VOLTAGE) || (addr == `PMR_ADDR_POWER) ||
              (addr == `PMR_ADDR_CURRENT) || (addr == `PMR_ADDR_CALIBRATION);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pmr_pkg::pmr_state_e state_reg;
  pmr_pkg::pmr_state_e state_next;
  pmr_pkg::pmr_word_t  bus_reg;
  pmr_pkg::pmr_word_t  bus_next;
  pmr_pkg::pmr_word_t  pwr_reg;
  pmr_pkg::pmr_word_t  pwr_next;
  pmr_pkg::pmr_word_t  cur_reg;
  pmr_pkg::pmr_word_t  cur_next;
  pmr_pkg::pmr_word_t  cal_reg;
  pmr_pkg::pmr_word_t  cal_next;
  pmr_pkg::pmr_word_t  shunt_hold_reg;
  pmr_pkg::pmr_word_t  shunt_hold_next;
  pmr_pkg::pmr_word_t  bus_hold_reg;
  pmr_pkg::pmr_word_t  bus_hold_next;
  pmr_pkg::pmr_word_t  cur_calc_reg;
  pmr_pkg::pmr_word_t  cur_calc_next;
  pmr_pkg::pmr_word_t  rdata_next;
  logic                upd_next;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  logic signed [31:0] cur_prod;
  logic signed [31:0] cur_scaled;
  logic        [15:0] cur_mag;
  logic        [31:0] pwr_prod;
  logic        [31:0] pwr_scaled;

  // RULE7 shunt times calibration
  // RULE11 two's complement drop
  assign cur_prod   = $signed(shunt_hold_reg) * $signed({17'h00000, cal_reg[14:0]});
  assign cur_scaled = cur_prod >>> `PMR_CUR_SHIFT;

  // RULE6 power magnitude only
  assign cur_mag    = cur_calc_reg[15] ? 16'(-cur_calc_reg) : cur_calc_reg;

  // RULE5 current times bus
  // RULE4 twenty-five current steps
  assign pwr_prod   = {16'h0000, cur_mag} * {17'h00000, bus_hold_reg[14:0]};
  assign pwr_scaled = pwr_prod / `PMR_PWR_DIV;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next      = state_reg;
    bus_next        = bus_reg;
    pwr_next        = pwr_reg;
    cur_next        = cur_reg;
    cal_next        = cal_reg;
    shunt_hold_next = shunt_hold_reg;
    bus_hold_next   = bus_hold_reg;
    cur_calc_next   = cur_calc_reg;
    upd_next        = 1'b0;
    rdata_next      = reg_rdata;

    // RULE9 calibration write
    // RULE10 top bit dropped
    if (reg_wr && (reg_addr == `PMR_ADDR_CALIBRATION))
    begin
      cal_next = {1'b0, reg_wdata[`PMR_MAG_MSB:0]};
    end

    // RULE13 staged, consistent update
    case (state_reg)
      pmr_pkg::PMR_IDLE:
      begin
        // RULE2 finished readings only
        if (meas_valid)
        begin
          // RULE12 raw 2.5 uV counts
          shunt_hold_next = shunt_drop_reading;
          bus_hold_next   = {1'b0, bus_voltage_reading[`PMR_MAG_MSB:0]};
          state_next      = pmr_pkg::PMR_CUR;
        end
      end
      pmr_pkg::PMR_CUR:
      begin
        // RULE8 signed, saturated current
        if (cur_scaled > $signed({16'h0000, `PMR_SMAX}))
          cur_calc_next = `PMR_SMAX;
        else if (cur_scaled < $signed({16'hffff, `PMR_SMIN}))
          cur_calc_next = `PMR_SMIN;
        else
          cur_calc_next = cur_scaled[15:0];
        state_next = pmr_pkg::PMR_PWR;
      end
      pmr_pkg::PMR_PWR:
      begin
        // RULE1 newer bus reading
        // RULE3 top bit zero
        bus_next   = bus_hold_reg;
        cur_next   = cur_calc_reg;
        pwr_next   = (pwr_scaled > {16'h0000, `PMR_UMAX}) ? `PMR_UMAX : pwr_scaled[15:0];
        upd_next   = 1'b1;
        state_next = pmr_pkg::PMR_IDLE;
      end
      default:
      begin
        state_next = pmr_pkg::PMR_IDLE;
      end
    endcase

    // read data; unmapped pointers return zero
    if (reg_rd)
    begin
      if (!pmr_hit(reg_addr))
        rdata_next = `PMR_RESET_WORD;
      else if (reg_addr == `PMR_ADDR_BUS_VOLTAGE)
        rdata_next = bus_reg;
      else if (reg_addr == `PMR_ADDR_POWER)
        rdata_next = pwr_reg;
      else if (reg_addr == `PMR_ADDR_CURRENT)
        rdata_next = cur_reg;
      else
        rdata_next = cal_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // RULE14 zero on reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg       <= pmr_pkg::PMR_IDLE;
      bus_reg         <= `PMR_RESET_WORD;
      pwr_reg         <= `PMR_RESET_WORD;
      cur_reg         <= `PMR_RESET_WORD;
      cal_reg         <= `PMR_RESET_WORD;
      shunt_hold_reg  <= `PMR_RESET_WORD;
      bus_hold_reg    <= `PMR_RESET_WORD;
      cur_calc_reg    <= `PMR_RESET_WORD;
      reg_rdata       <= `PMR_RESET_WORD;
      results_updated <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      bus_reg         <= bus_next;
      pwr_reg         <= pwr_next;
      cur_reg         <= cur_next;
      cal_reg         <= cal_next;
      shunt_hold_reg  <= shunt_hold_next;
      bus_hold_reg    <= bus_hold_next;
      cur_calc_reg    <= cur_calc_next;
      reg_rdata       <= rdata_next;
      results_updated <= upd_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_bus_top_zero: assert property ( // RULE3
    @(posedge sys_clk) disable iff (sys_rst) !bus_reg[15])
    else $error("bus result top bit set");

  chk_cal_top_zero: assert property ( // RULE10
    @(posedge sys_clk) disable iff (sys_rst) !cal_reg[15])
    else $error("calibration top bit set");

  chk_cal_write: assert property ( // RULE9
    @(posedge sys_clk) disable iff (sys_rst)
    reg_wr && reg_addr == `PMR_ADDR_CALIBRATION |=> cal_reg == {1'b0, $past(reg_wdata[14:0])})
    else $error("calibration write not stored");

  chk_update_timing: assert property ( // RULE13
    @(posedge sys_clk) disable iff (sys_rst)
    state_reg == pmr_pkg::PMR_IDLE && meas_valid |-> ##3 results_updated)
    else $error("results not updated three cycles after reading");

  chk_bus_follows: assert property ( // RULE1
    @(posedge sys_clk) disable iff (sys_rst)
    state_reg == pmr_pkg::PMR_IDLE && meas_valid
    |-> ##3 bus_reg == {1'b0, $past(bus_voltage_reading[14:0], 3)})
    else $error("bus result not taken from reading");

  chk_stable_between: assert property ( // RULE2
    @(posedge sys_clk) disable iff (sys_rst)
    !$past(upd_next) && !$past(sys_rst) |-> $stable(cur_reg) && $stable(pwr_reg))
    else $error("results changed outside an update");

  chk_power_zero: assert property ( // RULE5
    @(posedge sys_clk) disable iff (sys_rst)
    results_updated && (cur_reg == 16'h0000 || bus_reg == 16'h0000) |-> pwr_reg == 16'h0000)
    else $error("power nonzero with zero factor");

  chk_zero_cal: assert property ( // RULE7
    @(posedge sys_clk) disable iff (sys_rst)
    results_updated && cal_reg == 16'h0000 && $past(cal_reg, 2) == 16'h0000
    |-> cur_reg == 16'h0000)
    else $error("current nonzero with zero calibration");

  chk_sign_follow: assert property ( // RULE8
    @(posedge sys_clk) disable iff (sys_rst)
    results_updated && cur_reg[15] |-> $past(shunt_hold_reg[15], 2))
    else $error("current negative from positive drop");

  chk_unmapped_read: assert property ( // unmapped pointers read zero
    @(posedge sys_clk) disable iff (sys_rst)
    reg_rd && !pmr_hit(reg_addr) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  chk_reset_clear: assert property ( // RULE14
    @(posedge sys_clk) $past(sys_rst) && !sys_rst
    |-> bus_reg == 16'h0000 && pwr_reg == 16'h0000 &&
        cur_reg == 16'h0000 && cal_reg == 16'h0000)
    else $error("registers not cleared by reset");

endmodule

`default_nettype wire

// ===== pmr_defines.svh
// constants for the power monitor result register bank
// assumes a byte-wide register pointer driven by the serial port logic
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

// register pointer values
`define PMR_ADDR_BUS_VOLTAGE 8'h02
`define PMR_ADDR_POWER       8'h03
`define PMR_ADDR_CURRENT     8'h04
`define PMR_ADDR_CALIBRATION 8'h05

// reset value of every register in the bank
`define PMR_RESET_WORD 16'h0000

// magnitude field of bus and calibration words
`define PMR_MAG_MSB 14

// shunt drop weight, in nanovolts per count, full scale code
`define PMR_SHUNT_LSB_NV 2500
`define PMR_SHUNT_FULL   16'h7fff

// current = (shunt drop * calibration) >>> this shift
`define PMR_CUR_SHIFT 11

// power step is 25 current steps; bus step is 1.25 mV, so divide by 20000
`define PMR_PWR_STEP_RATIO 25
`define PMR_PWR_DIV        32'd20000

// saturation limits
`define PMR_SMAX 16'h7fff
`define PMR_SMIN 16'h8000
`define PMR_UMAX 16'hffff

`endif

// ===== pmr_pkg.sv
// types shared by the power monitor result register bank
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package pmr_pkg;

  // result update sequencer states
  typedef enum logic [1:0]
  {
    PMR_IDLE = 2'b00,
    PMR_CUR  = 2'b01,
    PMR_PWR  = 2'b10
  } pmr_state_e;

  typedef logic [15:0] pmr_word_t;

endpackage

`default_nettype wire

// ===== pmr_host_model.sv
// host side model: register pointer, write and read strobes
// assumes one clock shared with the register bank, read data one edge late
`include "pmr_defines.svh"
`default_nettype none

module pmr_host_model
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rdata,
  output var  logic [7:0]  reg_addr,
  output var  logic        reg_wr,
  output var  logic [15:0] reg_wdata,
  output var  logic        reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // idle levels before the first access
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  // one word, strobe held for one sampling edge
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;  // released data shows no stale value
  endtask

  // data taken once the sampling edge has landed
  task automatic read_word(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

// ===== power_monitor_result_registers_tb.sv
// self-checking bench for the result and calibration register bank
// assumes the host model drives the register port, bench drives readings
`include "pmr_defines.svh"
`default_nettype none

module power_monitor_result_registers_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk;
  logic        sys_rst;
  logic        meas_valid;
  logic [15:0] shunt_drop_reading;
  logic [15:0] bus_voltage_reading;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        results_updated;
  logic [15:0] cal_word;
  int          errors;
  int          checks_done;

  // ----------------------------------------
  // instances
  // ----------------------------------------
  pmr_host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  pmr_result_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .meas_valid(meas_valid),
    .shunt_drop_reading(shunt_drop_reading), .bus_voltage_reading(bus_voltage_reading),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .results_updated(results_updated));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 8 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  // signed product, shifted, saturated
  function automatic logic [15:0] exp_cur(logic [15:0] s, logic [15:0] c);
    longint p;
    p = (longint'($signed(s)) * longint'(c[14:0])) >>> `PMR_CUR_SHIFT;
    if (p > 32767)
      return 16'h7fff;
    if (p < -32768)
      return 16'h8000;
    return p[15:0];
  endfunction

  // magnitude of current times bus, saturated unsigned
  function automatic logic [15:0] exp_pwr(logic [15:0] i, logic [15:0] b);
    longint a;
    a = longint'($signed(i));
    if (a < 0)
      a = -a;
    a = a * longint'(b[14:0]) / 20000;
    return (a > 65535) ? 16'hffff : a[15:0];
  endfunction

  // one conversion, then all three results read back
  task automatic measure(input logic [15:0] s, input logic [15:0] b);
    int          n;
    logic [15:0] d;
    logic [15:0] cur;
    @(posedge sys_clk);
    meas_valid          <= 1'b1;
    shunt_drop_reading  <= s;
    bus_voltage_reading <= b;
    @(posedge sys_clk);
    meas_valid          <= 1'b0;
    shunt_drop_reading  <= ~s;  // readings released after the pulse
    bus_voltage_reading <= ~b;
    n = 0;
    while (results_updated !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 8)
      begin
        errors++;
        close_out();
      end
    end
    // pulse shows two edges after the taking edge
    chk("update latency", 16'h0002, 16'(n));
    cur = exp_cur(s, cal_word);
    host.read_word(`PMR_ADDR_BUS_VOLTAGE, d);
    chk("bus voltage", {1'b0, b[14:0]}, d);
    host.read_word(`PMR_ADDR_POWER, d);
    chk("power", exp_pwr(cur, b), d);
    host.read_word(`PMR_ADDR_CURRENT, d);
    chk("current", cur, d);
  endtask

  task automatic set_cal(input logic [15:0] c);
    host.write_word(`PMR_ADDR_CALIBRATION, c);
    cal_word = {1'b0, c[14:0]};
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values();
    logic [15:0] d;
    for (int a = 2; a <= 5; a++)
    begin
      host.read_word(8'(a), d);
      chk("reset word", `PMR_RESET_WORD, d);
    end
    host.read_word(8'h07, d);
    chk("unmapped read", 16'h0000, d);
    measure(16'h1000, 16'h2710);
  endtask

  task automatic cal_write();
    logic [15:0] d;
    set_cal(16'h8123);
    host.read_word(`PMR_ADDR_CALIBRATION, d);
    chk("calibration", 16'h0123, d);
    host.write_word(`PMR_ADDR_CURRENT, 16'hffff);
    host.read_word(`PMR_ADDR_CURRENT, d);
    chk("read-only current", 16'h0000, d);
  endtask

  task automatic readings();
    set_cal(16'h0800);
    measure(16'h1000, 16'ha710);
    measure(16'h8300, 16'h2710);
    set_cal(16'h0400);
    measure(16'h1000, 16'h2710);
    set_cal(16'h7fff);
    measure(16'h7fff, 16'h7fff);
    measure(16'h8000, 16'h7fff);
  endtask

  // second reset in mid-run, with all four registers loaded
  task automatic reset_again();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cal_word = `PMR_RESET_WORD;
    reset_values();
  endtask

  // main sequence, reset held three edges
  initial
  begin
    errors              = 0;
    checks_done         = 0;
    cal_word            = 16'h0000;
    sys_rst             = 1'b1;
    meas_valid          = 1'b0;
    shunt_drop_reading  = 16'h0000;
    bus_voltage_reading = 16'h0000;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    reset_values();
    cal_write();
    readings();
    reset_again();
    close_out();
  end
endmodule

`default_nettype wire
